// ---- dual_timer_counter_block.sv ----
// Summary of operation
// [R1] Mode register: timer one in bits 7..4, timer zero in bits 3..0.
// [R2] Gate enable set: counting also needs the timer's interrupt pin high.
// [R3] Select 1 counts count-pin events, select 0 counts machine cycles.
// [R4] Mode bits: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split.
// [R5] Count only when run is 1 and gate is 0 or pin high.
// [R6] Timer operation increments once per twelve-clock machine cycle.
// [R7] Rolling over to zero sets that timer's overflow flag.
// [R8] Control bits: ovf1, run1, ovf0, run0, edge1, type1, edge0, type0.
// [R9] Edge flags set by pin edges, cleared when interrupt is processed.
// [R10] Count pins sampled at T10; high then low gives one count.
// [R11] Count inputs must not toggle faster than one 24th of clock.
// [R12] Mode 0: 8-bit high byte behind 5-bit low-byte prescaler.
// [R13] Mode 1: full 16-bit counter, no prescaler.
// [R14] Mode 2: low byte counts, reloads from high byte on overflow.
// [R15] Timer one in mode 3 holds its value as if stopped.
// [R16] Timer zero mode 3: low byte is 8-bit counter with timer zero controls.
// [R17] Timer zero mode 3: high byte counts cycles, uses run1 and ovf1.
// [R18] Timer one overflow pulses go out as baud clock.
// [R19] Trigger type 1 selects falling edge, 0 low level; writable.
// [R20] All four count bytes readable and writable, write takes effect at once.
`timescale 1ns/1ps
module dual_timer_counter_block (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [timer_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [timer_pkg::DATA_W-1:0]   pwdata,
    output logic      [timer_pkg::DATA_W-1:0]   prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           ext_irq_pin_zero,
    input  wire logic                           ext_irq_pin_one,
    input  wire logic                           count_pin_zero,
    input  wire logic                           count_pin_one,
    input  wire logic                           ack_ovf_zero,
    input  wire logic                           ack_ovf_one,
    input  wire logic                           ack_edge_zero,
    input  wire logic                           ack_edge_one,
    output logic      [7:0]                     timer_flags,
    output logic                                baud_tick_one
);
    import timer_pkg::*;

    logic [7:0]  timer_mode_reg;
    logic [7:0]  timer_ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  low_count_byte_zero;
    logic [7:0]  high_count_byte_zero;
    logic [7:0]  low_count_byte_one;
    logic [7:0]  high_count_byte_one;
    logic [3:0]  phase_reg;
    logic [3:0]  pins_s;
    logic [1:0]  irq_prev_reg;
    logic [1:0]  cnt_samp_reg;
    logic [1:0]  cnt_prev_reg;
    logic [DATA_W-1:0] rdata_next;
    logic        rerr_next;
    mode_nib_s   nib_zero;
    mode_nib_s   nib_one;
    count_s      cnt_zero;
    count_s      cnt_one;
    logic [1:0]  sync_fill_reg;
    logic        tick, acc, wr;
    logic        wr_ctrl, wr_mode, wr_low0, wr_low1, wr_high0, wr_high1;
    logic        split_zero, run_zero, run_one;
    logic        inc_zero, inc_one, inc_high0, ovf_high0;
    logic        ovf_zero_set, ovf_one_set;
    logic [1:0]  irq_fall, irq_low, edge_set, cnt_event;

    // Next count value for one timer in the given mode
    function automatic count_s next_count(input logic [1:0] mode,
                                          input logic [7:0] hi,
                                          input logic [7:0] lo,
                                          input logic       inc);
        count_s      r;
        logic [12:0] v13;
        logic [15:0] v16;
        r.hi  = hi;
        r.lo  = lo;
        r.ovf = 1'b0;
        v13   = {hi, lo[4:0]};
        v16   = {hi, lo};
        if (inc) begin
            case (mode)
                MODE_13BIT: begin // [R12]
                    r.ovf = &v13;
                    v13   = 13'(v13 + 13'h1);
                    r.hi  = v13[12:5];
                    r.lo  = {lo[7:5], v13[4:0]};
                end
                MODE_16BIT: begin // [R13]
                    r.ovf = &v16;
                    v16   = 16'(v16 + 16'h1);
                    r.hi  = v16[15:8];
                    r.lo  = v16[7:0];
                end
                MODE_RELOAD: begin // [R14]
                    r.ovf = &lo;
                    r.lo  = (&lo) ? hi : 8'(lo + 8'h1);
                end
                default: begin // [R16]
                    r.ovf = &lo;
                    r.lo  = 8'(lo + 8'h1);
                end
            endcase
        end
        return r;
    endfunction : next_count

    pin_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   ({count_pin_one, count_pin_zero, ext_irq_pin_one, ext_irq_pin_zero}),
        .dout  (pins_s)
    );

    // APB decode; writes land in the second access cycle
    assign acc      = psel & penable & pready;
    assign wr       = acc & pwrite;
    assign wr_ctrl  = wr && (paddr == ADDR_CTRL);
    assign wr_mode  = wr && (paddr == ADDR_MODE);
    assign wr_low0  = wr && (paddr == ADDR_LOW_ZERO);
    assign wr_low1  = wr && (paddr == ADDR_LOW_ONE);
    assign wr_high0 = wr && (paddr == ADDR_HIGH_ZERO);
    assign wr_high1 = wr && (paddr == ADDR_HIGH_ONE);

    always_comb begin
        rerr_next  = 1'b0;
        rdata_next = '0;
        case (paddr)
            ADDR_CTRL:      rdata_next[7:0] = timer_ctrl_reg;
            ADDR_MODE:      rdata_next[7:0] = timer_mode_reg;
            ADDR_LOW_ZERO:  rdata_next[7:0] = low_count_byte_zero; // [R20]
            ADDR_LOW_ONE:   rdata_next[7:0] = low_count_byte_one;
            ADDR_HIGH_ZERO: rdata_next[7:0] = high_count_byte_zero;
            ADDR_HIGH_ONE:  rdata_next[7:0] = high_count_byte_one;
            default:        rerr_next       = 1'b1;
        endcase
    end

    // One wait state keeps prdata and pready straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            if (psel && penable && !pready) begin
                prdata  <= pwrite ? '0 : rdata_next;
                pslverr <= rerr_next;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_mode_reg <= MODE_RST;
        end else if (wr_mode) begin
            timer_mode_reg <= pwdata[7:0]; // [R1]
        end
    end

    assign nib_one  = timer_mode_reg[MODE_ONE_LSB +: 4]; // [R1]
    assign nib_zero = timer_mode_reg[MODE_ZERO_LSB +: 4];

    // Machine cycle phase, 0..11
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 4'h0;
        end else begin
            phase_reg <= (phase_reg == PH_TICK) ? 4'h0 : 4'(phase_reg + 4'h1); // [R6]
        end
    end

    assign tick = (phase_reg == PH_TICK);

    // Count pins: one sample per machine cycle, so pins faster than clk/24 alias
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_samp_reg <= 2'h0;
            cnt_prev_reg <= 2'h0;
        end else if (phase_reg == PH_SAMPLE) begin
            cnt_samp_reg <= pins_s[3:2]; // [R10] [R11]
            cnt_prev_reg <= cnt_samp_reg;
        end
    end

    assign cnt_event = cnt_prev_reg & ~cnt_samp_reg; // [R10]

    // Run qualification per timer
    assign run_zero   = timer_ctrl_reg[CB_RUN_ZERO] & (~nib_zero.gate | pins_s[0]); // [R2] [R5]
    assign run_one    = timer_ctrl_reg[CB_RUN_ONE] & (~nib_one.gate | pins_s[1]);   // [R2] [R5]
    assign split_zero = (nib_zero.mode == MODE_SPLIT);

    assign inc_zero  = tick & run_zero & (nib_zero.sel ? cnt_event[0] : 1'b1); // [R3] [R6]
    assign inc_one   = tick & run_one & (nib_one.sel ? cnt_event[1] : 1'b1)
                       & (nib_one.mode != MODE_SPLIT);                         // [R3] [R15]
    assign inc_high0 = tick & split_zero & timer_ctrl_reg[CB_RUN_ONE];         // [R17]
    assign ovf_high0 = inc_high0 & (&high_count_byte_zero);

    assign cnt_zero = next_count(nib_zero.mode, high_count_byte_zero,
                                 low_count_byte_zero, inc_zero);  // [R4]
    assign cnt_one  = next_count(nib_one.mode, high_count_byte_one,
                                 low_count_byte_one, inc_one);    // [R4]

    assign ovf_zero_set = cnt_zero.ovf;                                   // [R7] [R16]
    assign ovf_one_set  = split_zero ? ovf_high0 : cnt_one.ovf;           // [R7] [R17]

    // Software write replaces the count at once, ahead of counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_count_byte_zero  <= COUNT_RST;
            high_count_byte_zero <= COUNT_RST;
        end else begin
            low_count_byte_zero  <= wr_low0 ? pwdata[7:0] : cnt_zero.lo; // [R20]
            if (wr_high0) begin
                high_count_byte_zero <= pwdata[7:0];                      // [R20]
            end else if (split_zero) begin
                high_count_byte_zero <= 8'(high_count_byte_zero + {7'h0, inc_high0}); // [R17]
            end else begin
                high_count_byte_zero <= cnt_zero.hi;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_count_byte_one  <= COUNT_RST;
            high_count_byte_one <= COUNT_RST;
        end else begin
            low_count_byte_one  <= wr_low1 ? pwdata[7:0] : cnt_one.lo;   // [R20]
            high_count_byte_one <= wr_high1 ? pwdata[7:0] : cnt_one.hi;  // [R20]
        end
    end

    // Serial port baud source; exists even while the flag is lent out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_tick_one <= 1'b0;
        end else begin
            baud_tick_one <= cnt_one.ovf; // [R18]
        end
    end

    // Pins idle high but the sync resets low: no flags until it has filled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev_reg  <= 2'h3;
            sync_fill_reg <= 2'h0;
        end else begin
            irq_prev_reg  <= pins_s[1:0];
            sync_fill_reg <= {sync_fill_reg[0], 1'b1};
        end
    end

    assign irq_low     = ~pins_s[1:0] & {2{sync_fill_reg[1]}};
    assign irq_fall    = irq_prev_reg & irq_low;
    assign edge_set[0] = timer_ctrl_reg[CB_TYPE_ZERO] ? irq_fall[0] : irq_low[0]; // [R19]
    assign edge_set[1] = timer_ctrl_reg[CB_TYPE_ONE] ? irq_fall[1] : irq_low[1];  // [R19]

    // Acks clear, software write next, hardware set wins over both
    always_comb begin
        ctrl_next = timer_ctrl_reg;
        if (ack_ovf_zero) ctrl_next[CB_OVF_ZERO] = 1'b0;
        if (ack_ovf_one) ctrl_next[CB_OVF_ONE] = 1'b0;
        if (ack_edge_zero) ctrl_next[CB_EDGE_ZERO] = 1'b0; // [R9]
        if (ack_edge_one) ctrl_next[CB_EDGE_ONE] = 1'b0;   // [R9]
        if (wr_ctrl) ctrl_next = pwdata[7:0];              // [R8] [R19]
        if (ovf_zero_set) ctrl_next[CB_OVF_ZERO] = 1'b1;   // [R7]
        if (ovf_one_set) ctrl_next[CB_OVF_ONE] = 1'b1;     // [R7] [R17]
        if (edge_set[0]) ctrl_next[CB_EDGE_ZERO] = 1'b1;   // [R9]
        if (edge_set[1]) ctrl_next[CB_EDGE_ONE] = 1'b1;    // [R9]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_ctrl_reg <= CTRL_RST;
            timer_flags    <= CTRL_RST;
        end else begin
            timer_ctrl_reg <= ctrl_next; // [R8]
            timer_flags    <= ctrl_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_timer_cycle_inc;
        (tick && run_zero && !nib_zero.sel && nib_zero.mode == MODE_16BIT
         && low_count_byte_zero != 8'hFF && !wr_low0)
        |=> low_count_byte_zero == 8'($past(low_count_byte_zero) + 8'h1);
    endproperty
    a_timer_cycle_inc: assert property (p_timer_cycle_inc) // [R6]
        else $error("timer zero did not step once per machine cycle");

    property p_no_step_off_tick;
        (!tick && !wr_low0) |=> $stable(low_count_byte_zero);
    endproperty
    a_no_step_off_tick: assert property (p_no_step_off_tick) // [R6]
        else $error("timer zero low byte moved between machine cycles");

    property p_gate_blocks;
        (nib_zero.gate && !pins_s[0] && !wr_low0 && !wr_high0 && !split_zero)
        |=> $stable({high_count_byte_zero, low_count_byte_zero});
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) // [R2]
        else $error("timer zero counted with gate pin low");

    property p_rollover_flag;
        (inc_zero && nib_zero.mode == MODE_16BIT
         && {high_count_byte_zero, low_count_byte_zero} == 16'hFFFF && !wr_low0 && !wr_high0)
        |=> low_count_byte_zero == 8'h00 ##0 timer_ctrl_reg[CB_OVF_ZERO];
    endproperty
    a_rollover_flag: assert property (p_rollover_flag) // [R7]
        else $error("16-bit rollover did not set overflow flag zero");

    property p_reload;
        (inc_one && nib_one.mode == MODE_RELOAD && low_count_byte_one == 8'hFF
         && !wr_low1 && !wr_high1)
        |=> low_count_byte_one == high_count_byte_one && $stable(high_count_byte_one);
    endproperty
    a_reload: assert property (p_reload) // [R14]
        else $error("reload mode did not copy high byte into low byte");

    property p_one_held_split;
        (nib_one.mode == MODE_SPLIT && !wr_low1 && !wr_high1)
        |=> $stable({high_count_byte_one, low_count_byte_one}) && !baud_tick_one;
    endproperty
    a_one_held_split: assert property (p_one_held_split) // [R15]
        else $error("timer one moved while in mode 3");

    property p_high0_split;
        (split_zero && !wr_high0 && !(tick && timer_ctrl_reg[CB_RUN_ONE]))
        |=> $stable(high_count_byte_zero);
    endproperty
    a_high0_split: assert property (p_high0_split) // [R17]
        else $error("split high byte counted without run one and tick");

    property p_edge_flag;
        (timer_ctrl_reg[CB_TYPE_ZERO] && !wr_ctrl && irq_prev_reg[0] && !pins_s[0])
        |=> timer_ctrl_reg[CB_EDGE_ZERO] [*1] ##1 1'b1;
    endproperty
    a_edge_flag: assert property (p_edge_flag) // [R9]
        else $error("falling edge on interrupt pin zero not flagged");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) // [R20]
        else $error("pready held longer than one cycle");

endmodule : dual_timer_counter_block

// ---- timer_pkg.sv ----
package timer_pkg;

    // APB address width and data width
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL        = 8'h88;
    localparam logic [7:0]  IDX_MODE        = 8'h89;
    localparam logic [7:0]  IDX_LOW_ZERO    = 8'h8A;
    localparam logic [7:0]  IDX_LOW_ONE     = 8'h8B;
    localparam logic [7:0]  IDX_HIGH_ZERO   = 8'h8C;
    localparam logic [7:0]  IDX_HIGH_ONE    = 8'h8D;

    localparam logic [ADDR_W-1:0] ADDR_CTRL      = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_MODE      = {2'h0, IDX_MODE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LOW_ZERO  = {2'h0, IDX_LOW_ZERO, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LOW_ONE   = {2'h0, IDX_LOW_ONE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_HIGH_ZERO = {2'h0, IDX_HIGH_ZERO, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_HIGH_ONE  = {2'h0, IDX_HIGH_ONE, 2'h0};

    // Mode register nibble positions
    localparam int unsigned MODE_ONE_LSB    = 4;
    localparam int unsigned MODE_ZERO_LSB   = 0;

    // Control register bit positions
    localparam int unsigned CB_OVF_ONE      = 7;
    localparam int unsigned CB_RUN_ONE      = 6;
    localparam int unsigned CB_OVF_ZERO     = 5;
    localparam int unsigned CB_RUN_ZERO     = 4;
    localparam int unsigned CB_EDGE_ONE     = 3;
    localparam int unsigned CB_TYPE_ONE     = 2;
    localparam int unsigned CB_EDGE_ZERO    = 1;
    localparam int unsigned CB_TYPE_ZERO    = 0;

    // Mode encodings
    localparam logic [1:0]  MODE_13BIT      = 2'h0;
    localparam logic [1:0]  MODE_16BIT      = 2'h1;
    localparam logic [1:0]  MODE_RELOAD     = 2'h2;
    localparam logic [1:0]  MODE_SPLIT      = 2'h3;

    // Machine cycle: twelve clock periods, pclk taken as the oscillator
    localparam int unsigned MC_PERIODS      = 12;
    localparam logic [3:0]  PH_SAMPLE       = 4'h9;
    localparam logic [3:0]  PH_TICK         = 4'(MC_PERIODS - 1);

    // Reset values
    localparam logic [7:0]  MODE_RST        = 8'h00;
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [7:0]  COUNT_RST       = 8'h00;

    typedef struct packed {
        logic       gate;
        logic       sel;
        logic [1:0] mode;
    } mode_nib_s;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic       ovf;
    } count_s;

endpackage : timer_pkg

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;

    // Only the second stage is visible outside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule : pin_sync

// ---- ext_pins_model.sv ----
`timescale 1ns/1ps
module ext_pins_model (
    input  wire logic pclk,
    output logic      count_pin_zero,
    output logic      ext_irq_pin_zero,
    output logic      ext_irq_pin_one
);
    initial begin
        count_pin_zero   = 1'b0;
        // Interrupt pins idle high, as gating and level trigger expect
        ext_irq_pin_zero = 1'b1;
        ext_irq_pin_one  = 1'b1;
    end

    // Each level held 24 clocks, well above the minimum, so no event aliases
    task automatic count_pulses(input int n);
        repeat (n) begin
            @(posedge pclk);
            count_pin_zero <= 1'b1;
            repeat (24) @(posedge pclk);
            count_pin_zero <= 1'b0;
            repeat (23) @(posedge pclk);
        end
    endtask : count_pulses

    task automatic set_irq(input logic v);
        @(posedge pclk);
        ext_irq_pin_zero <= v;
    endtask : set_irq
endmodule : ext_pins_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import timer_pkg::*;
    localparam logic [ADDR_W-1:0] REGS [6] = '{ADDR_CTRL, ADDR_MODE, ADDR_LOW_ZERO,
                                               ADDR_LOW_ONE, ADDR_HIGH_ZERO, ADDR_HIGH_ONE};
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              cnt0;
    logic              irq0;
    logic              irq1;
    logic              ack_ovf0;
    logic              ack_edge0;
    logic              cnt1;
    logic              ack_ovf1;
    logic              ack_edge1;
    logic [7:0]        timer_flags;
    logic              baud;
    logic [DATA_W-1:0] rd;
    logic              err;
    int                cyc;
    int                land;
    int                n_baud;
    int                n_fail;
    int                samples_checked;

    dual_timer_counter_block DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_pin_zero(irq0), .ext_irq_pin_one(irq1), .count_pin_zero(cnt0),
        .count_pin_one(cnt1), .ack_ovf_zero(ack_ovf0), .ack_ovf_one(ack_ovf1),
        .ack_edge_zero(ack_edge0), .ack_edge_one(ack_edge1), .timer_flags(timer_flags),
        .baud_tick_one(baud));

    ext_pins_model PINS (.pclk(pclk), .count_pin_zero(cnt0), .ext_irq_pin_zero(irq0),
        .ext_irq_pin_one(irq1));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Ceiling far above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (baud === 1'b1) n_baud <= n_baud + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("TB: checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd   = prdata;
        err  = pslverr;
        land = cyc;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rdchk

    // Ticks fall between two write landings; span must be whole machine cycles
    task automatic timed(input logic [ADDR_W-1:0] a, input logic [7:0] d, input int n,
                         output int k);
        int l1;
        l1 = land;
        repeat (n) @(posedge pclk);
        wr(a, d);
        chk(32'((land - l1) % 12), 32'h0);
        k = (land - l1) / 12;
    endtask : timed

    task automatic t_regs;
        foreach (REGS[i]) rdchk(REGS[i], 8'h00);
        wr(12'h000, 8'hA5);
        apb(1'b0, 12'h000, 8'h00);
        chk({rd[30:0], err}, 32'h1);
        foreach (REGS[i]) if (i > 1) wr(REGS[i], 8'h11 * i[7:0]);
        foreach (REGS[i]) if (i > 1) rdchk(REGS[i], 8'h11 * i[7:0]);
        wr(ADDR_MODE, 8'hA6);
        rdchk(ADDR_MODE, 8'hA6);
        $display("TB: registers done");
    endtask : t_regs

    task automatic t_mode16;
        int k;
        logic [15:0] e;
        wr(ADDR_LOW_ZERO, 8'hFE);
        wr(ADDR_HIGH_ZERO, 8'hFF);
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_CTRL, 8'h10);
        PINS.set_irq(1'b0);
        timed(ADDR_MODE, 8'h09, 31, k);
        e = 16'hFFFE + 16'(k);
        repeat (30) @(posedge pclk);
        rdchk(ADDR_LOW_ZERO, e[7:0]);
        rdchk(ADDR_HIGH_ZERO, e[15:8]);
        chk(timer_flags, 8'h32);
        PINS.set_irq(1'b1);
        $display("TB: mode 1 done");
    endtask : t_mode16

    task automatic t_reload;
        int k;
        int b0;
        logic [7:0] e;
        wr(ADDR_HIGH_ONE, 8'hF0);
        wr(ADDR_LOW_ONE, 8'hFE);
        wr(ADDR_MODE, 8'h20);
        b0 = n_baud;
        wr(ADDR_CTRL, 8'h40);
        timed(ADDR_MODE, 8'h30, 44, k);
        e = (k < 2) ? 8'hFE + 8'(k) : 8'hF0 + 8'(k - 2);
        repeat (40) @(posedge pclk);
        rdchk(ADDR_LOW_ONE, e);
        rdchk(ADDR_HIGH_ONE, 8'hF0);
        chk(timer_flags, 8'hC0);
        chk(32'(n_baud - b0), 32'h1);
        ack_ovf1 <= 1'b1;
        @(posedge pclk);
        ack_ovf1 <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(timer_flags, 8'h40);
        $display("TB: mode 2 done");
    endtask : t_reload

    task automatic t_mode13;
        int k;
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_LOW_ZERO, 8'hFF);
        wr(ADDR_HIGH_ZERO, 8'hFF);
        wr(ADDR_CTRL, 8'h10);
        timed(ADDR_MODE, 8'h04, 8, k);
        rdchk(ADDR_LOW_ZERO, {3'h7, 5'(k - 1)});
        rdchk(ADDR_HIGH_ZERO, 8'h00);
        chk(timer_flags, 8'h30);
        ack_ovf0 <= 1'b1;
        @(posedge pclk);
        ack_ovf0 <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(timer_flags, 8'h10);
        $display("TB: mode 0 done");
    endtask : t_mode13

    task automatic t_counter;
        wr(ADDR_LOW_ZERO, 8'h00);
        wr(ADDR_MODE, 8'h05);
        repeat (30) @(posedge pclk);
        rdchk(ADDR_LOW_ZERO, 8'h00);
        PINS.count_pulses(3);
        repeat (48) @(posedge pclk);
        wr(ADDR_MODE, 8'h0D);
        rdchk(ADDR_LOW_ZERO, 8'h03);
        $display("TB: counter done");
    endtask : t_counter

    task automatic t_edge;
        wr(ADDR_CTRL, 8'h01);
        PINS.set_irq(1'b1);
        repeat (6) @(posedge pclk);
        PINS.set_irq(1'b0);
        repeat (6) @(posedge pclk);
        chk(timer_flags, 8'h03);
        ack_edge0 <= 1'b1;
        @(posedge pclk);
        ack_edge0 <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(timer_flags, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        repeat (4) @(posedge pclk);
        chk(timer_flags, 8'h02);
        $display("TB: edge flags done");
    endtask : t_edge

    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = '0;
        pwdata    = '0;
        ack_ovf0  = 1'b0;
        ack_edge0 = 1'b0;
        cnt1      = 1'b0;
        ack_ovf1  = 1'b0;
        ack_edge1 = 1'b0;
        cyc       = 0;
        land      = 0;
        n_baud    = 0;
        n_fail    = 0;
        samples_checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_mode16();
        t_reload();
        t_mode13();
        t_counter();
        t_edge();
        end_of_test();
    end
endmodule : testbench
